// file: core/prfd_pkg.sv
// prfd_pkg: register map, field positions, reset values and prescaler
// codes of the pll reference/feedback divider block.
// assumes a 32-bit classic wishbone slave, one register per aligned word.
package prfd_pkg;

  // counter widths
  localparam int PRFD_R_W = 14;
  localparam int PRFD_A_W = 6;
  localparam int PRFD_B_W = 13;
  localparam int PRFD_P_W = 3;
  localparam int PRFD_PC_W = 6;

  // bus geometry
  localparam int PRFD_ADR_W = 10;
  localparam int PRFD_IDX_W = 8;

  // register indices; the byte address is four times the index
  localparam logic [7:0] PRFD_IDX_A_VAL = 8'h04;
  localparam logic [7:0] PRFD_IDX_B_HI = 8'h05;
  localparam logic [7:0] PRFD_IDX_B_LO = 8'h06;
  localparam logic [7:0] PRFD_IDX_CNT_RST = 8'h09;
  localparam logic [7:0] PRFD_IDX_FB_CTRL = 8'h0A;
  localparam logic [7:0] PRFD_IDX_R_HI = 8'h0B;
  localparam logic [7:0] PRFD_IDX_R_LO = 8'h0C;
  localparam logic [7:0] PRFD_IDX_SRC_SEL = 8'h45;
  localparam logic [7:0] PRFD_IDX_STATUS = 8'h50;

  // field positions
  localparam int PRFD_RST_ALL_BIT = 0;
  localparam int PRFD_RST_AB_BIT = 1;
  localparam int PRFD_B_BYPASS_BIT = 6;
  localparam int PRFD_PSC_LSB = 0;
  localparam int PRFD_SRC_SEL_BIT = 0;
  localparam int PRFD_R_HI_W = 6;
  localparam int PRFD_B_HI_W = 5;
  localparam int PRFD_ST_UP_BIT = 0;
  localparam int PRFD_ST_DN_BIT = 1;
  localparam int PRFD_ST_BAD_BIT = 2;
  localparam int PRFD_ST_SRC_BIT = 3;

  // reset values and the minimum B
  localparam logic [7:0] PRFD_RST_ZERO = 8'h00;
  localparam logic PRFD_SRC_SEL_RST = 1'b1;
  localparam int PRFD_B_MIN = 3;

  // prescaler setting codes
  typedef enum logic [2:0] {
    PRFD_PSC_FD1 = 3'h0,
    PRFD_PSC_FD2 = 3'h1,
    PRFD_PSC_FD3 = 3'h2,
    PRFD_PSC_DM2 = 3'h3,
    PRFD_PSC_DM4 = 3'h4,
    PRFD_PSC_DM8 = 3'h5,
    PRFD_PSC_DM16 = 3'h6,
    PRFD_PSC_DM32 = 3'h7
  } prfd_psc_type;

  // base modulus of a prescaler setting
  function automatic logic [5:0] prfd_psc_base(input prfd_psc_type psc);
    logic [5:0] p;
    p = 6'h01;
    unique case (psc)
      PRFD_PSC_FD1: p = 6'h01;
      PRFD_PSC_FD2: p = 6'h02;
      PRFD_PSC_FD3: p = 6'h03;
      PRFD_PSC_DM2: p = 6'h02;
      PRFD_PSC_DM4: p = 6'h04;
      PRFD_PSC_DM8: p = 6'h08;
      PRFD_PSC_DM16: p = 6'h10;
      PRFD_PSC_DM32: p = 6'h20;
    endcase
    return p;
  endfunction : prfd_psc_base

  function automatic logic prfd_psc_is_dm(input prfd_psc_type psc);
    return psc >= PRFD_PSC_DM2;
  endfunction : prfd_psc_is_dm

endpackage : prfd_pkg

// file: core/prfd_div.sv
// prfd_div: programmable modulo divider, one output pulse per full count.
// assumes tick is a one-cycle pulse per input edge in the sys_clk domain.
`timescale 1ns/1ps
module prfd_div
  import prfd_pkg::*;
#(
  parameter int W = PRFD_R_W
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic tick,
  input wire logic [W-1:0] div_val,
  output logic pulse
);

  if (W < 1) begin : g_chk
    $error("prfd_div: divider width must be at least one");
  end

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic pulse_ff;
  logic nxt_pulse;
  logic [W-1:0] last;

  always_comb begin
    // zero divides by one, same as one
    last = (div_val == '0) ? '0 : div_val - W'(1);
    nxt_cnt = cnt_ff;
    nxt_pulse = 1'b0;
    if (clr) begin
      nxt_cnt = '0;
    end else if (tick) begin
      if (cnt_ff >= last) begin
        // reload so the next period starts without a gap
        nxt_cnt = '0;
        nxt_pulse = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      pulse_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse = pulse_ff;

endmodule : prfd_div

// file: core/prfd_top.sv
// prfd_top: pll reference divider, p/a/b feedback divider, digital phase
// frequency detector and distribution source select, behind wishbone.
// assumes clock inputs are synchronous to sys_clk and far slower than it,
// so each input edge is seen as one sampled rising edge.
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module prfd_top
  import prfd_pkg::*;
#(
  parameter int R_W = PRFD_R_W,
  parameter int A_W = PRFD_A_W,
  parameter int B_W = PRFD_B_W
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [PRFD_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reference_clock_input,
  input wire logic feedback_clock_input,
  input wire logic primary_clock_input,
  output logic dist_clock_out,
  output logic ref_div_pulse,
  output logic fb_div_pulse,
  output logic pfd_up,
  output logic pfd_down
);

  if (R_W < 2 || R_W > PRFD_R_W || A_W < 1 || A_W > PRFD_A_W ||
      B_W < 2 || B_W > PRFD_B_W) begin : g_chk
    $error("prfd_top: counter widths exceed register fields");
  end

  // the prescaler counter must reach the largest dual-modulus stage, 33
  if (PRFD_PC_W < 6) begin : g_pc_chk
    $error("prfd_top: prescaler counter too narrow");
  end

  // register file
  logic [7:0] a_val_ff, nxt_a_val;
  logic [7:0] b_hi_ff, nxt_b_hi;
  logic [7:0] b_lo_ff, nxt_b_lo;
  logic [7:0] cnt_rst_ff, nxt_cnt_rst;
  logic [7:0] fb_ctrl_ff, nxt_fb_ctrl;
  logic [7:0] r_hi_ff, nxt_r_hi;
  logic [7:0] r_lo_ff, nxt_r_lo;
  logic src_sel_ff, nxt_src_sel;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic [PRFD_IDX_W-1:0] idx;
  logic wr_now;
  logic [7:0] status;

  // datapath
  logic ref_prev_ff, fb_prev_ff;
  logic nxt_ref_prev, nxt_fb_prev;
  logic ref_tick, fb_tick;
  logic dist_ff, nxt_dist;
  logic [PRFD_PC_W-1:0] pc_ff, nxt_pc;
  logic [B_W-1:0] bc_ff, nxt_bc;
  logic fb_pulse_ff, nxt_fb_pulse;
  logic up_ff, nxt_up;
  logic dn_ff, nxt_dn;
  logic ref_pulse;
  logic clr_all, clr_ab;
  logic [R_W-1:0] r_val;
  logic [A_W-1:0] a_val;
  logic [B_W-1:0] b_val, b_load;
  prfd_psc_type psc;
  logic dm, bypass, cfg_bad;
  logic [5:0] p_base, modulus;

  assign idx = wb_adr_i[PRFD_ADR_W-1:2];
  // write lands on the edge where the master sees ack
  assign wr_now = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];

  assign r_val = R_W'({r_hi_ff[PRFD_R_HI_W-1:0], r_lo_ff});
  assign a_val = a_val_ff[A_W-1:0];
  assign b_val = B_W'({b_hi_ff[PRFD_B_HI_W-1:0], b_lo_ff});
  assign psc = prfd_psc_type'(fb_ctrl_ff[PRFD_PSC_LSB +: PRFD_P_W]);
  assign dm = prfd_psc_is_dm(psc);
  assign bypass = fb_ctrl_ff[PRFD_B_BYPASS_BIT];
  assign p_base = prfd_psc_base(psc);
  // bypass makes B a single stage
  assign b_load = bypass ? B_W'(1) : b_val;
  // reset bits stay asserted while set, holding the counters cleared
  assign clr_all = cnt_rst_ff[PRFD_RST_ALL_BIT];
  assign clr_ab = clr_all | cnt_rst_ff[PRFD_RST_AB_BIT];
  // bad settings only raise a status bit; the counters keep running, except that a B of zero without bypass stops the feedback counter
  assign cfg_bad = bypass ? dm
                 : (b_val < B_W'(PRFD_B_MIN));

  assign status = {4'h0, src_sel_ff, cfg_bad, dn_ff, up_ff};

  function automatic logic [7:0] rd_byte(input logic [PRFD_IDX_W-1:0] i,
                                         input logic [7:0] st);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      PRFD_IDX_A_VAL: v = a_val_ff;
      PRFD_IDX_B_HI: v = b_hi_ff;
      PRFD_IDX_B_LO: v = b_lo_ff;
      PRFD_IDX_CNT_RST: v = cnt_rst_ff;
      PRFD_IDX_FB_CTRL: v = fb_ctrl_ff;
      PRFD_IDX_R_HI: v = r_hi_ff;
      PRFD_IDX_R_LO: v = r_lo_ff;
      PRFD_IDX_SRC_SEL: v = {7'h00, src_sel_ff};
      PRFD_IDX_STATUS: v = st;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  // a counter wraps on the tick that finds it at or past its last state
  function automatic logic at_last(input logic [15:0] cnt,
                                   input logic [15:0] last);
    return cnt >= last;
  endfunction : at_last

  // bus slave and register next state
  always_comb begin
    nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_dat = ack_ff ? 32'h0000_0000 : {24'h00_0000, rd_byte(idx, status)};
    nxt_a_val = a_val_ff;
    nxt_b_hi = b_hi_ff;
    nxt_b_lo = b_lo_ff;
    nxt_cnt_rst = cnt_rst_ff;
    nxt_fb_ctrl = fb_ctrl_ff;
    nxt_r_hi = r_hi_ff;
    nxt_r_lo = r_lo_ff;
    nxt_src_sel = src_sel_ff;
    // reserved bits are stored as zero so a read shows only live fields
    if (wr_now) begin
      unique case (idx)
        PRFD_IDX_A_VAL: nxt_a_val = {2'h0, wb_dat_i[5:0]};
        PRFD_IDX_B_HI: nxt_b_hi = {3'h0, wb_dat_i[4:0]};
        PRFD_IDX_B_LO: nxt_b_lo = wb_dat_i[7:0];
        PRFD_IDX_CNT_RST: nxt_cnt_rst = {6'h00, wb_dat_i[1:0]};
        PRFD_IDX_FB_CTRL: nxt_fb_ctrl = {1'b0, wb_dat_i[6], 3'h0,
                                         wb_dat_i[2:0]};
        PRFD_IDX_R_HI: nxt_r_hi = {2'h0, wb_dat_i[5:0]};
        PRFD_IDX_R_LO: nxt_r_lo = wb_dat_i[7:0];
        PRFD_IDX_SRC_SEL: nxt_src_sel = wb_dat_i[PRFD_SRC_SEL_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      a_val_ff <= PRFD_RST_ZERO;
      b_hi_ff <= PRFD_RST_ZERO;
      b_lo_ff <= PRFD_RST_ZERO;
      cnt_rst_ff <= PRFD_RST_ZERO;
      fb_ctrl_ff <= PRFD_RST_ZERO;
      r_hi_ff <= PRFD_RST_ZERO;
      r_lo_ff <= PRFD_RST_ZERO;
      src_sel_ff <= PRFD_SRC_SEL_RST;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      a_val_ff <= nxt_a_val;
      b_hi_ff <= nxt_b_hi;
      b_lo_ff <= nxt_b_lo;
      cnt_rst_ff <= nxt_cnt_rst;
      fb_ctrl_ff <= nxt_fb_ctrl;
      r_hi_ff <= nxt_r_hi;
      r_lo_ff <= nxt_r_lo;
      src_sel_ff <= nxt_src_sel;
    end
  end

  // input edges; the primary input never reaches the feedback counters
  assign ref_tick = reference_clock_input & ~ref_prev_ff;
  assign fb_tick = feedback_clock_input & ~fb_prev_ff;

  // the distribution copy is registered, so it trails the selected pin
  // by one cycle and is a sampled level, not a real clock path
  always_comb begin
    nxt_ref_prev = reference_clock_input;
    nxt_fb_prev = feedback_clock_input;
    nxt_dist = src_sel_ff ? primary_clock_input
                          : feedback_clock_input;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_prev_ff <= 1'b0;
      fb_prev_ff <= 1'b0;
      dist_ff <= 1'b0;
    end else begin
      ref_prev_ff <= nxt_ref_prev;
      fb_prev_ff <= nxt_fb_prev;
      dist_ff <= nxt_dist;
    end
  end

  prfd_div #(
    .W(R_W)
  ) u_ref_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clr(clr_all),
    .tick(ref_tick),
    .div_val(r_val),
    .pulse(ref_pulse)
  );

  // feedback divider: prescaler stages counted by B; the first A stages
  // run at P+1 in dual-modulus mode, so N = P*B + A there and P*B in
  // fixed mode. A must not exceed B or the extra stages are lost.
  always_comb begin
    modulus = (dm && (B_W'(a_val) > bc_ff)) ?
              p_base + 6'h01 : p_base;
    nxt_pc = pc_ff;
    nxt_bc = bc_ff;
    nxt_fb_pulse = 1'b0;
    if (clr_ab) begin
      nxt_pc = '0;
      nxt_bc = '0;
    end else if (fb_tick && b_load != '0) begin
      if (at_last(16'(pc_ff), 16'(modulus - 6'h01))) begin
        nxt_pc = '0;
        if (at_last(16'(bc_ff), 16'(b_load - B_W'(1)))) begin
          nxt_bc = '0;
          nxt_fb_pulse = 1'b1;
        end else begin
          nxt_bc = bc_ff + B_W'(1);
        end
      end else begin
        nxt_pc = pc_ff + 6'h01;
      end
    end
  end

  // tri-state detector: whichever edge leads opens its output until
  // the other arrives, so pulse width tracks the phase error
  always_comb begin
    nxt_up = up_ff | ref_pulse;
    nxt_dn = dn_ff | fb_pulse_ff;
    if ((nxt_up && nxt_dn) || clr_all) begin
      nxt_up = 1'b0;
      nxt_dn = 1'b0;
    end
  end

  // feedback divider state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pc_ff <= '0;
      bc_ff <= '0;
      fb_pulse_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      bc_ff <= nxt_bc;
      fb_pulse_ff <= nxt_fb_pulse;
    end
  end

  // detector state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      up_ff <= 1'b0;
      dn_ff <= 1'b0;
    end else begin
      up_ff <= nxt_up;
      dn_ff <= nxt_dn;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign dist_clock_out = dist_ff;
  assign ref_div_pulse = ref_pulse;
  assign fb_div_pulse = fb_pulse_ff;
  assign pfd_up = up_ff;
  assign pfd_down = dn_ff;

endmodule : prfd_top

// file: test/prfd_top_sva.sv
// prfd_top_sva: port-level checks of the pll divider block.
// assumes the single sys_clk domain and the active-low nrst.
`timescale 1ns/1ps
module prfd_top_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic reference_clock_input,
  input wire logic feedback_clock_input,
  input wire logic ref_div_pulse,
  input wire logic fb_div_pulse,
  input wire logic pfd_up,
  input wire logic pfd_down
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_ack_one_shot: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_answer: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_ref_one_shot: assert property (ref_div_pulse |=> !ref_div_pulse)
    else $error("reference pulse wider than one cycle");
  a_ref_pulse_cause: assert property (
    ref_div_pulse |->
      $past(reference_clock_input) && !$past(reference_clock_input, 2))
    else $error("reference pulse without input edge");
  a_fb_one_shot: assert property (fb_div_pulse |=> !fb_div_pulse)
    else $error("feedback pulse wider than one cycle");
  a_fb_pulse_cause: assert property (
    fb_div_pulse |-> $past(feedback_clock_input))
    else $error("feedback pulse without feedback edge");
  a_pfd_exclusive: assert property (!(pfd_up && pfd_down))
    else $error("detector drives both directions");
  a_up_cause: assert property ($rose(pfd_up) |-> $past(ref_div_pulse))
    else $error("up set without reference pulse");
  a_down_cause: assert property (
    $rose(pfd_down) |-> $past(fb_div_pulse))
    else $error("down set without feedback pulse");
  c_fb_pulse: cover property (fb_div_pulse);
  c_up_set: cover property (ref_div_pulse ##1 pfd_up);
  c_bus: cover property (wb_ack_o);
endmodule : prfd_top_sva
bind prfd_top prfd_top_sva u_sva (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .reference_clock_input, .feedback_clock_input,
  .ref_div_pulse, .fb_div_pulse, .pfd_up, .pfd_down);

// file: test/prfd_clk_src.sv
// prfd_clk_src: behavioural reference source and oscillator.
// assumes rates far below sys_clk; lines stand low between bursts.
`timescale 1ns/1ps
module prfd_clk_src (
  input wire logic sys_clk,
  output logic ref_o,
  output logic fb_o,
  output logic pri_o
);
  initial begin
    ref_o = 1'b0;
    fb_o = 1'b0;
    pri_o = 1'b0;
  end
  // two cycles high, two low: each edge is slow enough to be sampled,
  // standing in for a rate below every detector and prescaler limit
  task automatic edges(input logic is_fb, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (is_fb) fb_o <= 1'b1;
      else ref_o <= 1'b1;
      repeat (2) @(posedge sys_clk);
      fb_o <= 1'b0;
      ref_o <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : edges
  task automatic levels(input logic f, input logic p);
    @(posedge sys_clk);
    fb_o <= f;
    pri_o <= p;
  endtask : levels
endmodule : prfd_clk_src

// file: test/testbench.sv
// testbench: register, divider and source-select scenarios.
// assumes prfd_top at default widths and the prfd_clk_src model.
`timescale 1ns/1ps
module testbench;
  import prfd_pkg::*;
  logic sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, v;
  logic reference_clock_input, feedback_clock_input, primary_clock_input;
  logic dist_clock_out, ref_div_pulse, fb_div_pulse, pfd_up, pfd_down;
  logic [31:0] exp_q[$];
  int fails, compares, ref_n, fb_n, seed, n, a;
  int pv[8] = '{1, 2, 3, 2, 4, 8, 16, 32};
  int bv[8] = '{0, 0, 3, 3, 3, 3, 3, 4};
  int av[8] = '{0, 0, 0, 1, 1, 2, 0, 1};
  prfd_top u_prfd_top (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .reference_clock_input, .feedback_clock_input, .primary_clock_input,
    .dist_clock_out, .ref_div_pulse, .fb_div_pulse, .pfd_up, .pfd_down);
  prfd_clk_src u_prfd_clk_src (.sys_clk, .ref_o(reference_clock_input),
    .fb_o(feedback_clock_input), .pri_o(primary_clock_input));
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic we, input logic [7:0] idx,
                     input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    // no fixed latency is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00);
  endtask : rd
  // counts divider pulses over n input edges of one clock
  task automatic cnt(input logic f, input int n, input int e);
    int c0;
    c0 = f ? fb_n : ref_n;
    u_prfd_clk_src.edges(f, n);
    repeat (4) @(posedge sys_clk);
    chk((f ? fb_n : ref_n) - c0, e);
  endtask : cnt
  // result side: pulses counted, read data matched against oldest note
  always @(posedge sys_clk) begin
    if (ref_div_pulse === 1'b1) ref_n <= ref_n + 1;
    if (fb_div_pulse === 1'b1) fb_n <= fb_n + 1;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      chk(wb_dat_o, exp_q.pop_front());
  end
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
  initial begin
    {sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h00;
    {wb_adr_i, wb_dat_i, fails, compares, ref_n, fb_n} = '0;
    wb_sel_i = 4'hF;
    seed = 66;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(8'h45, 8'h01);
    rd(8'h06, 8'h00);
    rd(8'h33, 8'h00);
    cnt(1'b1, 10, 0);
    v = $random(seed);
    bus(1'b1, 8'h0B, v[7:0]);
    rd(8'h0B, v[7:0] & 8'h3F);
    // a write without the low byte lane must leave the register alone
    wb_sel_i <= 4'hE;
    bus(1'b1, 8'h0B, 8'h3F);
    wb_sel_i <= 4'hF;
    rd(8'h0B, v[7:0] & 8'h3F);
    bus(1'b1, 8'h0B, 8'h00);
    cnt(1'b0, 4, 4);
    bus(1'b1, 8'h0B, 8'h01);
    bus(1'b1, 8'h0C, 8'h01);
    bus(1'b1, 8'h09, 8'h01);
    cnt(1'b0, 300, 0);
    bus(1'b1, 8'h09, 8'h00);
    cnt(1'b0, 514, 2);
    chk({30'h0, pfd_down, pfd_up}, 32'h1);
    rd(8'h50, 8'h0D);
    // bypass only with fixed modes; dual modes keep a within b
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      a = (i == 2) ? int'(v[5:0]) : av[i];
      n = (i < 2) ? pv[i] : pv[i] * bv[i] + ((i > 2) ? a : 0);
      bus(1'b1, 8'h06, bv[i][7:0]);
      bus(1'b1, 8'h04, a[7:0]);
      bus(1'b1, 8'h0A, {1'b0, i < 2, 3'h0, i[2:0]});
      rd(8'h0A, {1'b0, i < 2, 3'h0, i[2:0]});
      bus(1'b1, 8'h09, 8'h01);
      bus(1'b1, 8'h09, 8'h00);
      cnt(1'b1, 2 * n, 2);
    end
    chk({30'h0, pfd_down, pfd_up}, 32'h2);
    bus(1'b1, 8'h0B, 8'h00);
    cnt(1'b0, 1, 1);
    chk({30'h0, pfd_down, pfd_up}, 32'h0);
    bus(1'b1, 8'h09, 8'h02);
    cnt(1'b1, 200, 0);
    bus(1'b1, 8'h09, 8'h00);
    u_prfd_clk_src.levels(1'b1, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, dist_clock_out}, 32'h0);
    bus(1'b1, 8'h45, 8'h00);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, dist_clock_out}, 32'h1);
    u_prfd_clk_src.levels(1'b0, 1'b1);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, dist_clock_out}, 32'h0);
    chk(exp_q.size(), 32'h0);
    print_verdict();
  end
endmodule : testbench
